/* line_equipment.sv */
`timescale 1ns/1ps
module line_equipment (
  // From the block
  input  wire [3:0] line_out,
  input  wire [3:0] line_oe,
  // Levels the equipment puts on lines nobody else drives
  input  wire [5:0] ext_level,
  // Pin levels
  output wire [5:0] line_in
);
  // A driven pin shows the block's level; an undriven one shows the equipment's.
  assign line_in = {(line_oe & line_out) | (~line_oe & ext_level[5:2]), ext_level[1:0]};
endmodule // line_equipment

/* output_line_pulse_checker_asserts.sv */
`timescale 1ns/1ps
module output_line_pulse_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Lines
  input wire [5:0]  line_in,
  input wire [3:0]  line_out,
  input wire [3:0]  line_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Status reports the driven level on output lines, the pin on input lines.
  wire [5:0] stat = {(line_oe & line_out) | (~line_oe & line_in[5:2]), line_in[1:0]};
  wire       rd   = wb_ack_o && !wb_we_i;
  wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wr   = wb_cyc_i && wb_we_i;

  AST_ACK_FOLLOWS: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_INPUT_UNDRIVEN: assert property ((line_out & ~line_oe) == 4'h0)
    else $error("input line driven");
  AST_STATUS_VECTOR: assert property (rd && wb_adr_i == 8'h00 |-> wb_dat_o[5:0] == $past(stat))
    else $error("status vector wrong");
  AST_STROBE_READS_ZERO: assert property (rd && wb_adr_i == 8'h04 |-> wb_dat_o == 32'h0)
    else $error("strobe read not zero");
  AST_UNMAPPED_ZERO: assert property (rd && wb_adr_i[3:2] == 2'h3 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_OE_FROM_WRITE: assert property ($changed(line_oe) |-> $past(wr) || $past(wr, 2))
    else $error("direction changed without write");
  AST_STATIC_FOLLOW: assert property (take && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[0]
    && wb_dat_i[5:0] == 6'h03 |-> ##3 line_out[0] == $past(wb_dat_i[6], 3))
    else $error("static level not followed");

  CV_STATUS: cover property (rd && wb_adr_i == 8'h00);
  CV_PULSE: cover property ($rose(line_out[0]));
  CV_STROBE: cover property (take && wb_we_i && wb_adr_i == 8'h04);
endmodule // output_line_pulse_checker

bind output_line_pulse_control output_line_pulse_checker chk (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));

/* output_line_pulse_control.v */
`timescale 1ns/1ps
`include "output_line_pulse_defs.vh"

module output_line_pulse_control #(
  parameter NUM_LINES = 6,
  parameter OUT_LINES = 4,
  parameter FIRST_OUT = 2,
  parameter TIME_W    = 24,
  parameter STEP_W    = 6
) (
  // Clock and reset
  input  wire                 ref_clk,
  input  wire                 rst,
  // Wishbone slave
  input  wire                 wb_cyc_i,
  input  wire                 wb_stb_i,
  input  wire                 wb_we_i,
  input  wire [7:0]           wb_adr_i,
  input  wire [3:0]           wb_sel_i,
  input  wire [31:0]          wb_dat_i,
  output reg  [31:0]          wb_dat_o,
  output reg                  wb_ack_o,
  // Line pins and event sources
  input  wire [NUM_LINES-1:0] line_in,
  input  wire [OUT_LINES-1:0] event_src,
  output reg  [OUT_LINES-1:0] line_out,
  output reg  [OUT_LINES-1:0] line_oe
);

  // ----------------------------------------------------------------------
  // Sequencer states and timing constants
  // ----------------------------------------------------------------------
  localparam ST_IDLE   = 3'b001;
  localparam ST_DELAY  = 3'b010;
  localparam ST_ACTIVE = 3'b100;
  // The prescaler divides the clock down to one microsecond per step.
  localparam integer      STEP_LAST_I = `STEP_CYCLES - 1;
  localparam [STEP_W-1:0] STEP_LAST   = STEP_LAST_I[STEP_W-1:0];
  localparam [TIME_W-1:0] TIME_ONE    = {{(TIME_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------------
  // One-hot select of the per-line register block addressed, zero if none.
  function [OUT_LINES-1:0] line_hit;
    input [7:0] adr;
    integer     i;
    begin
      line_hit = {OUT_LINES{1'b0}};
      for (i = 0; i < OUT_LINES; i = i + 1) begin
        if (adr[7] == 1'b0 && adr[6:4] == `REG_LINE_BASE + i[2:0] && adr[3:2] != 2'h3)
          line_hit[i] = 1'b1;
      end
    end
  endfunction

  // Byte-lane merge of a write into an existing word.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] new_data;
    input [3:0]  sel;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b])
          merge[b*8 +: 8] = new_data[b*8 +: 8];
      end
    end
  endfunction

  // Decides what a strobe bit does: bit 1 fires a pulse, bit 0 commits the latched level.
  function [1:0] strobe_action;
    input [1:0] src;
    input       latch;
    begin
      strobe_action = 2'b00;
      if (src == `SRC_PULSE_SW)
        strobe_action[1] = 1'b1;
      else if (src == `SRC_SW_DRIVEN && latch)
        strobe_action[0] = 1'b1;
    end
  endfunction

  // Times above the sixteen-second ceiling are held at the ceiling.
  // Software reading a clamped time back sees the ceiling, not what it wrote.
  function [TIME_W-1:0] clamp;
    input [31:0] v;
    begin
      if (v > {8'h00, `TIME_MAX_US})
        clamp = `TIME_MAX_US;
      else
        clamp = v[TIME_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------------
  // Masking with ack keeps a request that the master still holds from being taken twice.
  wire                 req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                 wr     = req & wb_we_i;
  wire [OUT_LINES-1:0] hit    = line_hit(wb_adr_i);
  wire                 strobe_wr = wr && wb_adr_i == `REG_STROBE;
  wire [OUT_LINES-1:0] strobe = strobe_wr ? wb_dat_i[OUT_LINES-1:0] : {OUT_LINES{1'b0}};

  wire [OUT_LINES*32-1:0] line_rd;
  wire [NUM_LINES-1:0]    level;
  wire [OUT_LINES-1:0]    next_out;
  wire [OUT_LINES-1:0]    next_oe;

  // ----------------------------------------------------------------------
  // Per-line pulse and level logic
  // ----------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < OUT_LINES; k = k + 1) begin : g_line
      reg  [6:0]        cfg;
      reg  [TIME_W-1:0] dly;
      reg  [TIME_W-1:0] wid;
      reg  [2:0]        state;
      reg  [TIME_W-1:0] cnt;
      reg  [STEP_W-1:0] pre;
      reg               ev_prev;
      reg               latched;
      reg               value;

      wire       dir   = cfg[`CFG_DIR];
      wire [1:0] src   = cfg[`CFG_SRC_LO +: 2];
      wire [1:0] edg   = cfg[`CFG_EDGE_LO +: 2];
      wire       latch = cfg[`CFG_LATCH];
      wire [1:0] act   = strobe_action(src, latch);
      // Each source is compared with its value one clock earlier.
      wire       rise  = event_src[k] & ~ev_prev;
      wire       fall  = ~event_src[k] & ev_prev;
      // Edge code 3 is unused and never triggers.
      wire       edge_hit = (edg == `EDGE_UP     && rise) ||
                            (edg == `EDGE_DOWN   && fall) ||
                            (edg == `EDGE_EITHER && (rise || fall));
      // Strobe and event pulses share one sequencer, so a line runs one pulse at a time.
      wire       trig  = dir &&
                         ((strobe[k] && act[1]) ||
                          (src == `SRC_PULSE_EVT && edge_hit));
      wire       step_end = pre == STEP_LAST;
      wire [1:0] word  = wb_adr_i[3:2];
      wire       wr_k  = wr & hit[k];

      assign line_rd[k*32 +: 32] = (word == `REG_WORD_CFG)   ? {25'h0, cfg} :
                                   (word == `REG_WORD_DELAY) ? {8'h00, dly} :
                                                               {8'h00, wid};
      // Status shows the driven value of an output line rather than its pin.
      assign level[FIRST_OUT + k] = dir ? line_out[k] : line_in[FIRST_OUT + k];

      // ----------------------------------------------------------------------
      // Configuration registers
      // ----------------------------------------------------------------------
      // The latched level starts low, so a latched line stays open until its first strobe.
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          cfg     <= `CFG_RESET;
          dly     <= `TIME_RESET;
          wid     <= `TIME_RESET;
          latched <= 1'b0;
        end else begin
          // Config changes only when its low byte lane is enabled.
          if (wr_k && word == `REG_WORD_CFG && wb_sel_i[0])
            cfg <= wb_dat_i[6:0];
          if (wr_k && word == `REG_WORD_DELAY)
            dly <= clamp(merge({8'h00, dly}, wb_dat_i, wb_sel_i));
          if (wr_k && word == `REG_WORD_WIDTH)
            wid <= clamp(merge({8'h00, wid}, wb_dat_i, wb_sel_i));
          if (strobe[k] && act[0])
            latched <= cfg[`CFG_LEVEL];
        end
      end

      // ----------------------------------------------------------------------
      // Pulse sequencer
      // ----------------------------------------------------------------------
      // The prescaler restarts in idle, so each phase lasts whole microseconds.
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          state   <= ST_IDLE;
          cnt     <= `TIME_RESET;
          pre     <= {STEP_W{1'b0}};
          ev_prev <= 1'b0;
        end else begin
          ev_prev <= event_src[k];

          case (state)
            ST_IDLE: begin
              pre <= {STEP_W{1'b0}};
              // A zero delay starts the active phase at once and a zero width makes no pulse.
              if (trig) begin
                if (dly != `TIME_RESET) begin
                  state <= ST_DELAY;
                  cnt   <= dly;
                end else if (wid != `TIME_RESET) begin
                  state <= ST_ACTIVE;
                  cnt   <= wid;
                end
              end
            end
            // Triggers are not looked at outside idle, so they are dropped.
            ST_DELAY: begin
              pre <= step_end ? {STEP_W{1'b0}} : pre + 1'b1;
              if (step_end) begin
                // The count ends at one, so the phase lasts exactly the programmed steps.
                if (cnt == TIME_ONE) begin
                  if (wid != `TIME_RESET) begin
                    state <= ST_ACTIVE;
                    cnt   <= wid;
                  end else begin
                    state <= ST_IDLE;
                  end
                end else begin
                  cnt <= cnt - TIME_ONE;
                end
              end
            end
            ST_ACTIVE: begin
              pre <= step_end ? {STEP_W{1'b0}} : pre + 1'b1;
              if (step_end) begin
                if (cnt == TIME_ONE)
                  state <= ST_IDLE;
                else
                  cnt <= cnt - TIME_ONE;
              end
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end

      always @* begin
        case (src)
          `SRC_SW_DRIVEN: value = latch ? latched : cfg[`CFG_LEVEL];
          `SRC_PULSE_SW:  value = state == ST_ACTIVE;
          `SRC_PULSE_EVT: value = state == ST_ACTIVE;
          default:        value = 1'b0;
        endcase
      end

      // An input line is never driven and its output is parked low.
      assign next_out[k] = dir & value;
      assign next_oe[k]  = dir;
    end
  endgenerate

  // Lines below the first output line are inputs only and always report their pins.
  generate
    for (k = 0; k < FIRST_OUT; k = k + 1) begin : g_in_only
      assign level[k] = line_in[k];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  // Pins leave straight from flip-flops, so a bus write never glitches a line.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_out <= {OUT_LINES{1'b0}};
      line_oe  <= {OUT_LINES{1'b0}};
    end else begin
      line_out <= next_out;
      line_oe  <= next_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------------
  reg [31:0] next_dat;
  integer    j;

  // The status word is built before the taking edge, so it holds the levels at read time.
  // Unmapped addresses read as zero, and writes to them are dropped.
  always @* begin
    next_dat = 32'h00000000;
    if (wb_adr_i == `REG_STATUS)
      next_dat[NUM_LINES-1:0] = level;
    for (j = 0; j < OUT_LINES; j = j + 1) begin
      if (hit[j])
        next_dat = line_rd[j*32 +: 32];
    end
  end

  // One wait state: ack rises on the edge after the request and falls next.
  // Read data then stands until the next read replaces it.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= next_dat;
    end
  end

endmodule // output_line_pulse_control

/* output_line_pulse_control_tb.sv */
`timescale 1ns/1ps
module output_line_pulse_control_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  evt = 4'h0;
  logic [3:0]  sel = 4'hf;
  logic [5:0]  ext = 6'h00;
  wire  [31:0] rdat;
  wire         ack;
  wire  [5:0]  pins;
  wire  [3:0]  lout;
  wire  [3:0]  loe;
  logic [31:0] expq[$];
  int          fails = 0;
  int          num_checks = 0;

  output_line_pulse_control uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .line_in(pins), .event_src(evt), .line_out(lout), .line_oe(loe));
  line_equipment eq (.line_out(lout), .line_oe(loe), .ext_level(ext), .line_in(pins));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_line(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The request stays up until ack is seen, then idles one cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) begin
      @(posedge ref_clk);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] s, input logic [1:0] e,
                                      input logic l, input logic v);
    return {25'h0, v, l, e, s, 1'b1};
  endfunction

  always @(posedge ref_clk) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      chk_word(rdat, expq.pop_front());
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    report_and_stop;
  end

  initial begin
    logic [3:0] lv;
    void'($urandom(89117));
    ext <= 6'($urandom);
    lv = 4'($urandom);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h00, {26'h0, ext});
    for (int k = 0; k < 4; k++) bus(1'b1, 8'(16 * (k + 1)), cfg(2'h1, 2'h0, 1'b0, lv[k]));
    rd(8'h00, {26'h0, lv, ext[1:0]});
    for (int k = 0; k < 3; k++) bus(1'b1, 8'(16 * (k + 1)), cfg(2'h1, 2'h0, 1'b1, 1'b1));
    bus(1'b1, 8'h40, cfg(2'h0, 2'h0, 1'b0, 1'b1));
    rd(8'h00, {26'h0, 4'h0, ext[1:0]});
    bus(1'b1, 8'h04, 32'h9);
    rd(8'h00, {26'h0, 4'h1, ext[1:0]});
    bus(1'b1, 8'h04, 32'h6);
    rd(8'h00, {26'h0, 4'h7, ext[1:0]});
    bus(1'b1, 8'h10, cfg(2'h1, 2'h0, 1'b1, 1'b0));
    rd(8'h00, {26'h0, 4'h7, ext[1:0]});
    bus(1'b1, 8'h04, 32'h1);
    rd(8'h00, {26'h0, 4'h6, ext[1:0]});
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b1, 8'h18, 32'h1);
    for (int e = 0; e < 3; e++) begin
      bus(1'b1, 8'h10, cfg(2'h3, 2'(e), 1'b0, 1'b0));
      evt[0] <= 1'b1;
      repeat (30) @(posedge ref_clk);
      chk_line(lout[0], 1'b0);
      repeat (30) @(posedge ref_clk);
      chk_line(lout[0], e != 1);
      evt[0] <= 1'b0;
      repeat (60) @(posedge ref_clk);
      chk_line(lout[0], e == 1);
      repeat (60) @(posedge ref_clk);
    end
    bus(1'b1, 8'h28, 32'h1);
    bus(1'b1, 8'h20, cfg(2'h2, 2'h0, 1'b0, 1'b0));
    bus(1'b1, 8'h04, 32'h2);
    repeat (10) @(posedge ref_clk);
    chk_line(lout[1], 1'b1);
    repeat (40) @(posedge ref_clk);
    chk_line(lout[1], 1'b0);
    bus(1'b1, 8'h30, 32'h42);
    rd(8'h00, {26'h0, 1'b0, ext[4], 2'h0, ext[1:0]});
    sel <= 4'he;
    bus(1'b1, 8'h40, 32'h0);
    sel <= 4'hf;
    rd(8'h40, 32'h41);
    chk_word({28'h0, loe}, 32'hb);
    report_and_stop;
  end
endmodule // output_line_pulse_control_tb

/* output_line_pulse_defs.vh */
// Functional notes
// - With edge selection set to rising, a low-to-high change of the line's event source triggers its pulse.
// - With edge selection set to falling, only a high-to-low change of the event source triggers its pulse.
// - With edge selection set to either, both rising and falling changes of the event source trigger its pulse.
// - After a trigger the line waits the programmed delay, in microseconds, before its pulse starts.
// - Pulse delay and pulse generation act only on a line set as output, and an input line is never driven.
// - The pulse stays active for the programmed width in microseconds and then the line returns inactive.
// - With latch selection off, a software-driven line follows its static level at once.
// - With latch selection on, a software-driven line changes only when its strobe bit is written.
// - An active static level closes the output circuit and an inactive one opens it.
// - The all-lines status read returns every line level at read time, line 1 in bit 0, ascending.
// - A one in a strobe bit commits the latched level or fires the software pulse, and a zero does nothing.
// - Strobe bit 0 serves line 3, bit 1 line 4, bit 2 line 5, bit 3 line 6, and several may be set at once.
// - A strobe bit acts only on a line sourced by software strobe pulse or software-driven with latch on.
// - Delay and width are programmable from zero to sixteen seconds in one microsecond steps.
// - A line whose source is pulse on software strobe emits a pulse when its strobe event occurs.
`ifndef OUTPUT_LINE_PULSE_DEFS_VH
`define OUTPUT_LINE_PULSE_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (status and strobe as byte addresses, line block and word as address fields)
// ----------------------------------------------------------------------
`define REG_STATUS      8'h00
`define REG_STROBE      8'h04
`define REG_LINE_BASE   3'h1
`define REG_WORD_CFG    2'h0
`define REG_WORD_DELAY  2'h1
`define REG_WORD_WIDTH  2'h2

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define CFG_DIR         0
`define CFG_SRC_LO      1
`define CFG_EDGE_LO     3
`define CFG_LATCH       5
`define CFG_LEVEL       6
`define CFG_RESET       7'h00

`define SRC_OFF         2'h0
`define SRC_SW_DRIVEN   2'h1
`define SRC_PULSE_SW    2'h2
`define SRC_PULSE_EVT   2'h3

`define EDGE_UP         2'h0
`define EDGE_DOWN       2'h1
`define EDGE_EITHER     2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TIME_RESET      24'h000000
`define TIME_MAX_US     24'hf42400
`define CLK_MHZ         40
`define STEP_US         1
`define STEP_CYCLES     (`STEP_US * `CLK_MHZ)

`endif
